// File: sml_ctrl_model.sv
// Behavioural programming controller on supply line and output pin
`timescale 1ns/1ps
`default_nettype none
module sml_ctrl_model #(
   parameter int HALF = 150
)(
   input  wire logic clk_i,
   input  wire logic pin_i,
   input  wire logic oe_i,
   output logic      supply_o,
   output logic      strobe_o
);
   initial begin
      supply_o = 1'b1;
      strobe_o = 1'b0;
   end
   function automatic logic [2:0] crc3(input logic [37:0] v, input int n);
      logic [2:0] c;
      logic       fb;
      c = 3'h7;
      for (int i = n - 1; i >= 0; i--) begin
         fb = c[2] ^ v[i];
         c = {c[1], c[0] ^ fb, fb};
      end
      return c;
   endfunction
   task automatic hb(input logic v, input int n);
      supply_o = v;
      repeat (n) @(negedge clk_i);
   endtask
   // Sync zeros, payload, CRC; bad corrupts the CRC on purpose
   task automatic send(input logic [37:0] pl, input int n, input bit bad);
      logic [40:0] f;
      f = {pl, crc3(pl, n) ^ {2'b00, bad}};
      for (int i = n + 4; i >= 0; i--) begin
         hb(i > n + 2 ? 1'b0 : f[i], HALF);
         hb(i > n + 2 ? 1'b1 : ~f[i], HALF);
      end
      hb(1'b1, 6 * HALF);
   endtask
   task automatic strobe(input int n);
      strobe_o = 1'b1;
      repeat (n) @(negedge clk_i);
      strobe_o = 1'b0;
      repeat (4 * HALF) @(negedge clk_i);
   endtask
   // Samples mid-half; waiting for the answer is bounded
   task automatic recv(output logic [34:0] r, output bit ok);
      logic a;
      int   w;
      r = '0;
      w = 0;
      while (oe_i !== 1'b1 && w < 3000) begin
         @(negedge clk_i);
         w++;
      end
      ok = (oe_i === 1'b1);
      repeat (HALF / 2) @(negedge clk_i);
      for (int i = 0; i < 35; i++) begin
         a = pin_i;
         repeat (HALF) @(negedge clk_i);
         r = {r[33:0], a};
         ok = ok && (pin_i === ~a);
         repeat (HALF) @(negedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// File: sml_link.sv
// Manchester programming link: supply-line receiver, lock, response sender
// Functional notes
// - Mid-bit rising edge means zero, falling edge means one, both directions.
// - Address and data go most significant bit first and are assembled so.
// - Controller starts every transaction; sensor only answers received commands.
// - Only unlock, write and read are recognised; only read response is sent.
// - Reads get a response frame; unlock and write get no acknowledge.
// - Commands come on supply line; responses go out on output pin only.
// - Access code must be written within the unlock timeout after power-up.
// - Missing the timeout refuses all reads and writes until next power-up.
// - One detected strobe is needed before the cell gate is raised, during the next long strobe.
// - Unlock writes the 30-bit customer code to address 0x24 within 8 ms.
// - Frames end in a 3-bit CRC, init 111; bad CRC commands ignored.
`timescale 1ns/1ps
`default_nettype none
module sml_link
   import sml_pkg::*;
#(
   parameter logic [DATA_W-1:0] ACCESS_CODE = 30'h0,   // Arbitrary value
   parameter int                UNLOCK_CYC  = UNLOCK_TIMEOUT_CYC,
   parameter int                STROBE_CYC  = STROBE_MIN_CYC
)(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              supply_cmd_i,
   input  wire logic              strobe_i,
   input  wire logic [DATA_W-1:0] mem_rdata_i,
   output var  sml_mem_req_s      mem_req_o,
   output logic                   mem_vwr_o,
   output logic                   mem_rd_o,
   output logic                   nvm_gate_o,
   output logic                   nvm_commit_o,
   output logic                   unlocked_o,
   output logic                   locked_out_o,
   output logic                   sensor_output_pin_o,
   output logic                   sensor_output_pin_oe_o
);
   generate
      if (UNLOCK_CYC < 1 || UNLOCK_CYC >= (1 << 24) ||
          STROBE_CYC < 1 || STROBE_CYC >= (1 << 16)) begin : g_chk
         $error("sml_link: timing parameter out of range");
      end
   endgenerate

   localparam logic [23:0] UNLOCK_LIM = 24'(UNLOCK_CYC);
   localparam logic [15:0] STROBE_LIM = 16'(STROBE_CYC);

   // Receiver state
   sml_rx_e              rx_st_ff, nxt_rx_st;
   logic                 lvl_ff, nxt_lvl;
   logic [CNT_W-1:0]     cnt_ff, nxt_cnt;
   logic [CNT_W-1:0]     tbit_ff, nxt_tbit;
   logic [1:0]           edg_ff, nxt_edg;
   logic [WR_BITS-1:0]   sh_ff, nxt_sh;
   logic [NB_W-1:0]      nb_ff, nxt_nb;
   logic [CRC_W-1:0]     crc_ff, nxt_crc;
   logic                 frame_done;
   logic                 edge_seen;
   logic                 tx_busy;

   always_comb begin
      nxt_rx_st  = rx_st_ff;
      nxt_lvl    = supply_cmd_i;
      nxt_cnt    = (cnt_ff == {CNT_W{1'b1}}) ? cnt_ff : cnt_ff + 1'b1;
      nxt_tbit   = tbit_ff;
      nxt_edg    = edg_ff;
      nxt_sh     = sh_ff;
      nxt_nb     = nb_ff;
      nxt_crc    = crc_ff;
      frame_done = 1'b0;
      edge_seen  = supply_cmd_i ^ lvl_ff;
      case (rx_st_ff)
         RX_IDLE: begin
            // Idle line is high; a frame opens with a falling boundary edge
            if (edge_seen && !supply_cmd_i && !tx_busy) begin
               nxt_rx_st = RX_SYNC;
               nxt_cnt   = '0;
               nxt_edg   = 2'h0;
            end
         end
         RX_SYNC: begin
            if (edge_seen) begin
               nxt_edg = edg_ff + 1'b1;
               if (edg_ff == 2'h0) begin
                  nxt_cnt = '0;
                  if (!supply_cmd_i) begin
                     nxt_rx_st = RX_IDLE;
                  end
               end else if (edg_ff == 2'h2) begin
                  // Two sync zeros: rising to rising is one bit period
                  nxt_tbit  = cnt_ff;
                  nxt_cnt   = '0;
                  nxt_nb    = '0;
                  nxt_crc   = CRC_INIT;
                  nxt_rx_st = RX_DATA;
                  if (!supply_cmd_i || cnt_ff < TBIT_MIN ||
                      cnt_ff > TBIT_MAX) begin
                     nxt_rx_st = RX_IDLE;
                  end
               end
            end else if (cnt_ff > SYNC_LIMIT) begin
               nxt_rx_st = RX_IDLE;
            end
         end
         RX_DATA: begin
            // Boundary edges fall before three quarters of a period
            if (edge_seen && cnt_ff >= tbit_ff - (tbit_ff >> 2)) begin
               nxt_sh  = {sh_ff[WR_BITS-2:0], ~supply_cmd_i};
               nxt_nb  = (nb_ff == {NB_W{1'b1}}) ? nb_ff : nb_ff + 1'b1;
               nxt_crc = sml_crc_step(crc_ff, ~supply_cmd_i);
               nxt_cnt = '0;
            end else if (cnt_ff > tbit_ff + (tbit_ff >> 1)) begin
               frame_done = 1'b1;
               nxt_rx_st  = RX_IDLE;
            end
         end
         default: nxt_rx_st = RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_st_ff <= RX_IDLE;
         lvl_ff   <= 1'b1;
         cnt_ff   <= '0;
         tbit_ff  <= TBIT_MAX;
         edg_ff   <= 2'h0;
         sh_ff    <= '0;
         nb_ff    <= '0;
         crc_ff   <= CRC_INIT;
      end else begin
         rx_st_ff <= nxt_rx_st;
         lvl_ff   <= nxt_lvl;
         cnt_ff   <= nxt_cnt;
         tbit_ff  <= nxt_tbit;
         edg_ff   <= nxt_edg;
         sh_ff    <= nxt_sh;
         nb_ff    <= nxt_nb;
         crc_ff   <= nxt_crc;
      end
   end

   // Command decode, lock and non-volatile commit
   logic [23:0]  lk_cnt_ff, nxt_lk_cnt;
   logic         expired_ff, nxt_expired;
   logic         unl_ff, nxt_unl;
   sml_mem_req_s req_ff, nxt_req;
   logic         vwr_ff, nxt_vwr;
   logic         rd_ff, nxt_rd;
   logic         pend_ff, nxt_pend;
   logic         nstb_ff, nxt_nstb;
   logic [15:0]  stb_cnt_ff, nxt_stb_cnt;
   logic         stb_q_ff, nxt_stb_q;
   logic         gate_ff, nxt_gate;
   logic         commit_ff, nxt_commit;
   logic         crc_ok, wr_ok, rd_ok, long_stb;
   logic [ADDR_W-1:0] w_addr;
   logic [DATA_W-1:0] w_data;

   always_comb begin
      nxt_lk_cnt  = (lk_cnt_ff == UNLOCK_LIM) ? lk_cnt_ff : lk_cnt_ff + 1'b1;
      nxt_expired = expired_ff;
      nxt_unl     = unl_ff;
      nxt_req     = req_ff;
      nxt_vwr     = 1'b0;
      nxt_rd      = 1'b0;
      nxt_pend    = pend_ff;
      nxt_nstb    = nstb_ff;
      nxt_stb_q   = strobe_i;
      nxt_commit  = 1'b0;
      nxt_stb_cnt = !strobe_i ? 16'h0 :
                    (stb_cnt_ff == STROBE_LIM) ? stb_cnt_ff : stb_cnt_ff + 1'b1;
      long_stb    = stb_cnt_ff == STROBE_LIM;
      crc_ok      = crc_ff == 3'h0;
      w_addr      = sh_ff[WR_BITS-TYPE_W-1 -: ADDR_W];
      w_data      = sh_ff[CRC_W +: DATA_W];
      wr_ok = frame_done && crc_ok && nb_ff == WR_NB &&
              sh_ff[WR_BITS-1 -: TYPE_W] == CMD_WRITE;
      rd_ok = frame_done && crc_ok && nb_ff == RD_NB && unl_ff && !tx_busy &&
              sh_ff[RD_BITS-1 -: TYPE_W] == CMD_READ;
      // A strobe counts only once it has stayed high long enough
      // Commit clears first, so a write landing now stays pending
      if (pend_ff && stb_q_ff && !strobe_i && long_stb) begin
         if (!nstb_ff) begin
            nxt_nstb = 1'b1;
         end else begin
            nxt_commit = 1'b1;
            nxt_pend   = 1'b0;
         end
      end
      if (wr_ok && w_addr == UNLOCK_ADDR) begin
         if (w_data == ACCESS_CODE && !expired_ff) begin
            nxt_unl = 1'b1;
         end
      end else if (wr_ok && unl_ff) begin
         nxt_req = '{addr: w_addr, wdata: w_data};
         if (w_addr < NVM_LIMIT) begin
            nxt_pend = 1'b1;
            nxt_nstb = 1'b0;
         end else begin
            nxt_vwr = 1'b1;
         end
      end
      if (rd_ok) begin
         nxt_req.addr = sh_ff[RD_BITS-TYPE_W-1 -: ADDR_W];
         nxt_rd       = 1'b1;
      end
      // Expiry is judged after this cycle's unlock, so the two never overlap
      if (lk_cnt_ff == UNLOCK_LIM && !nxt_unl) begin
         nxt_expired = 1'b1;
      end
      nxt_gate = pend_ff && nstb_ff && strobe_i && long_stb;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk_cnt_ff  <= '0;
         expired_ff <= 1'b0;
         unl_ff     <= 1'b0;
         req_ff     <= '0;
         vwr_ff     <= 1'b0;
         rd_ff      <= 1'b0;
         pend_ff    <= 1'b0;
         nstb_ff    <= 1'b0;
         stb_cnt_ff <= '0;
         stb_q_ff   <= 1'b0;
         gate_ff    <= 1'b0;
         commit_ff  <= 1'b0;
      end else begin
         lk_cnt_ff  <= nxt_lk_cnt;
         expired_ff <= nxt_expired;
         unl_ff     <= nxt_unl;
         req_ff     <= nxt_req;
         vwr_ff     <= nxt_vwr;
         rd_ff      <= nxt_rd;
         pend_ff    <= nxt_pend;
         nstb_ff    <= nxt_nstb;
         stb_cnt_ff <= nxt_stb_cnt;
         stb_q_ff   <= nxt_stb_q;
         gate_ff    <= nxt_gate;
         commit_ff  <= nxt_commit;
      end
   end

   // Read response sender, timed from the bit period of the read frame
   sml_tx_e            tx_st_ff, nxt_tx_st;
   logic [CNT_W-1:0]   tcnt_ff, nxt_tcnt;
   logic [TX_BITS-1:0] tsh_ff, nxt_tsh;
   logic [NB_W-1:0]    tidx_ff, nxt_tidx;
   logic               half_ff, nxt_half;
   logic               pin_ff, nxt_pin;
   logic               oe_ff, nxt_oe;

   assign tx_busy = tx_st_ff != TX_IDLE;

   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_tcnt  = tcnt_ff + 1'b1;
      nxt_tsh   = tsh_ff;
      nxt_tidx  = tidx_ff;
      nxt_half  = half_ff;
      case (tx_st_ff)
         TX_IDLE: begin
            nxt_tcnt = '0;
            if (rd_ff) begin
               nxt_tx_st = TX_WAIT;
            end
         end
         TX_WAIT: begin
            if (tcnt_ff >= RD_DLY - (tbit_ff >> 2)) begin
               nxt_tsh   = {2'b00, mem_rdata_i,
                            sml_crc_word(mem_rdata_i)};
               nxt_tidx  = '0;
               nxt_half  = 1'b0;
               nxt_tcnt  = '0;
               nxt_tx_st = TX_SEND;
            end
         end
         TX_SEND: begin
            if (tcnt_ff >= (tbit_ff >> 1) - 1'b1) begin
               nxt_tcnt = '0;
               nxt_half = ~half_ff;
               if (half_ff) begin
                  nxt_tsh  = {tsh_ff[TX_BITS-2:0], 1'b0};
                  nxt_tidx = tidx_ff + 1'b1;
                  if (tidx_ff == TX_LAST) begin
                     nxt_tx_st = TX_IDLE;
                  end
               end
            end
         end
         default: nxt_tx_st = TX_IDLE;
      endcase
      // First half carries the bit, so a one ends in a falling mid edge
      nxt_oe  = nxt_tx_st == TX_SEND;
      nxt_pin = !nxt_oe ? 1'b1 :
                (nxt_half ? ~nxt_tsh[TX_BITS-1] : nxt_tsh[TX_BITS-1]);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_st_ff <= TX_IDLE;
         tcnt_ff  <= '0;
         tsh_ff   <= '0;
         tidx_ff  <= '0;
         half_ff  <= 1'b0;
         pin_ff   <= 1'b1;
         oe_ff    <= 1'b0;
      end else begin
         tx_st_ff <= nxt_tx_st;
         tcnt_ff  <= nxt_tcnt;
         tsh_ff   <= nxt_tsh;
         tidx_ff  <= nxt_tidx;
         half_ff  <= nxt_half;
         pin_ff   <= nxt_pin;
         oe_ff    <= nxt_oe;
      end
   end

   assign mem_req_o              = req_ff;
   assign mem_vwr_o              = vwr_ff;
   assign mem_rd_o               = rd_ff;
   assign nvm_gate_o             = gate_ff;
   assign nvm_commit_o           = commit_ff;
   assign unlocked_o             = unl_ff;
   assign locked_out_o           = expired_ff;
   assign sensor_output_pin_o    = pin_ff;
   assign sensor_output_pin_oe_o = oe_ff;
endmodule
`default_nettype wire

// File: sml_link_assertions.sv
// Port assertions for the supply-line programming link
`timescale 1ns/1ps
`default_nettype none
module sml_link_assertions
   import sml_pkg::*;
#(
   parameter int UNLOCK_CYC = UNLOCK_TIMEOUT_CYC,
   parameter int STROBE_CYC = STROBE_MIN_CYC
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic strobe_i,
   input wire logic mem_vwr_o,
   input wire logic mem_rd_o,
   input wire logic nvm_gate_o,
   input wire logic nvm_commit_o,
   input wire logic unlocked_o,
   input wire logic locked_out_o,
   input wire logic sensor_output_pin_o,
   input wire logic sensor_output_pin_oe_o
);
   int age_ff, cyc_ff, hi_ff;
   logic oe_q_ff, ans_ff;
   // age_ff and cyc_ff saturate so long idle spans never wrap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         age_ff <= 4000;
         cyc_ff <= 0;
         hi_ff <= 0;
         oe_q_ff <= 1'b0;
         ans_ff <= 1'b1;
      end else begin
         oe_q_ff <= sensor_output_pin_oe_o;
         // Cleared by a read, set again by the rising edge of its answer
         ans_ff <= mem_rd_o ? 1'b0 :
                   (ans_ff | (sensor_output_pin_oe_o & ~oe_q_ff));
         age_ff <= mem_rd_o ? 1 : (age_ff < 4000 ? age_ff + 1 : age_ff);
         cyc_ff <= cyc_ff < UNLOCK_CYC + 8 ? cyc_ff + 1 : cyc_ff;
         hi_ff <= strobe_i ? hi_ff + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_rd_answer: assert property (
      age_ff == 1201 |-> ans_ff)
      else $error("read not answered");
   chk_answer_cause: assert property (
      $rose(sensor_output_pin_oe_o) |-> age_ff >= 1000 && age_ff <= 1200)
      else $error("unsolicited answer");
   chk_sync_first: assert property (
      $rose(sensor_output_pin_oe_o) |-> !sensor_output_pin_o)
      else $error("answer not opening low");
   chk_idle_pin: assert property (
      !sensor_output_pin_oe_o |-> sensor_output_pin_o)
      else $error("pin not idle high");
   chk_access_gate: assert property (
      mem_rd_o || mem_vwr_o |-> unlocked_o && !locked_out_o)
      else $error("access while locked");
   chk_unlock_hold: assert property (unlocked_o |=> unlocked_o)
      else $error("unlock lost");
   chk_lock_time: assert property (
      !unlocked_o && cyc_ff >= UNLOCK_CYC + 4 |-> locked_out_o)
      else $error("timeout not locking");
   chk_gate_strobe: assert property (
      nvm_gate_o |-> hi_ff >= STROBE_CYC - 1)
      else $error("gate without long strobe");
   chk_commit_gate: assert property (
      nvm_commit_o |-> $past(nvm_gate_o) || $past(nvm_gate_o, 2))
      else $error("commit without gate");
endmodule
bind sml_link sml_link_assertions #(
   .UNLOCK_CYC(UNLOCK_CYC), .STROBE_CYC(STROBE_CYC)) u_chk (
   .clk_i, .rst_n_i, .strobe_i, .mem_vwr_o, .mem_rd_o, .nvm_gate_o,
   .nvm_commit_o, .unlocked_o, .locked_out_o, .sensor_output_pin_o,
   .sensor_output_pin_oe_o);
`default_nettype wire

// File: sml_pkg.sv
// Constants, types and CRC helpers for the supply-line programming link
package sml_pkg;
   localparam int CLK_HZ            = 25_000_000;
   localparam int UNLOCK_TIMEOUT_MS = 8;
   localparam int UNLOCK_TIMEOUT_CYC = CLK_HZ / 1000 * UNLOCK_TIMEOUT_MS;
   localparam int READ_DELAY_US     = 50;
   localparam int READ_DELAY_CYC    = CLK_HZ / 1_000_000 * READ_DELAY_US;
   localparam int STROBE_MIN_US     = 100;
   localparam int STROBE_MIN_CYC    = CLK_HZ / 1_000_000 * STROBE_MIN_US;
   localparam int BIT_RATE_MIN_BPS  = 32_000;
   localparam int BIT_RATE_MAX_BPS  = 80_000;
   localparam int BIT_CYC_LONG      = CLK_HZ / BIT_RATE_MIN_BPS;
   localparam int BIT_CYC_SHORT     = CLK_HZ / BIT_RATE_MAX_BPS;
   localparam int BIT_TOL_PCT       = 11;
   localparam int CNT_W             = 12;
   localparam logic [CNT_W-1:0] TBIT_MIN =
      CNT_W'(BIT_CYC_SHORT * (100 - BIT_TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] TBIT_MAX =
      CNT_W'(BIT_CYC_LONG * (100 + BIT_TOL_PCT) / 100);
   localparam logic [CNT_W-1:0] SYNC_LIMIT = CNT_W'(2 * TBIT_MAX);
   localparam logic [CNT_W-1:0] RD_DLY = CNT_W'(READ_DELAY_CYC);

   localparam int TYPE_W   = 2;
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 30;
   localparam int CRC_W    = 3;
   localparam int SYNC_N   = 2;
   localparam int RD_BITS  = TYPE_W + ADDR_W + CRC_W;
   localparam int WR_BITS  = TYPE_W + ADDR_W + DATA_W + CRC_W;
   localparam int TX_BITS  = SYNC_N + DATA_W + CRC_W;
   localparam int NB_W     = 6;
   localparam logic [NB_W-1:0] RD_NB = NB_W'(RD_BITS);
   localparam logic [NB_W-1:0] WR_NB = NB_W'(WR_BITS);
   localparam logic [NB_W-1:0] TX_LAST = NB_W'(TX_BITS - 1);
   localparam logic [CRC_W-1:0] CRC_INIT = 3'h7;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 6'h24;
   localparam logic [ADDR_W-1:0] NVM_LIMIT = 6'h20;

   typedef enum logic [1:0] {
      CMD_NONE  = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_READ  = 2'b10,
      CMD_SPARE = 2'b11
   } sml_cmd_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_SYNC = 2'b01,
      RX_DATA = 2'b10
   } sml_rx_e;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } sml_tx_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sml_mem_req_s;

   // Polynomial x3+x+1, message fed most significant bit first
   function automatic logic [CRC_W-1:0] sml_crc_step(
      input logic [CRC_W-1:0] crc, input logic din);
      logic fb;
      fb = crc[2] ^ din;
      return {crc[1], crc[0] ^ fb, fb};
   endfunction

   function automatic logic [CRC_W-1:0] sml_crc_word(
      input logic [DATA_W-1:0] d);
      logic [CRC_W-1:0] c;
      c = CRC_INIT;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         c = sml_crc_step(c, d[i]);
      end
      return c;
   endfunction
endpackage

// File: tb.sv
// Self-checking bench for the supply-line programming link
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sml_pkg::*;
   localparam int UNL = 16000;
   localparam int STB = 20;
   localparam logic [DATA_W-1:0] CODE = 30'h15A3C7E9; // Arbitrary value
   localparam logic [DATA_W-1:0] WD = 30'h0C3A5F12;
   logic clk_i, rst_n_i, supply, strobe, gate, commit, rd, vwr;
   logic unl, lko, pin, oe, oe_q;
   logic [DATA_W-1:0] rdata;
   sml_mem_req_s req;
   int err_count = 0, cmp_count = 0;
   int n_rd = 0, n_vwr = 0, n_com = 0, n_oe = 0, n_gate = 0;

   sml_link #(.ACCESS_CODE(CODE), .UNLOCK_CYC(UNL), .STROBE_CYC(STB)) u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_cmd_i(supply),
      .strobe_i(strobe), .mem_rdata_i(rdata), .mem_req_o(req),
      .mem_vwr_o(vwr), .mem_rd_o(rd), .nvm_gate_o(gate),
      .nvm_commit_o(commit), .unlocked_o(unl), .locked_out_o(lko),
      .sensor_output_pin_o(pin), .sensor_output_pin_oe_o(oe));
   sml_ctrl_model u_ctrl (.clk_i(clk_i), .pin_i(pin), .oe_i(oe),
      .supply_o(supply), .strobe_o(strobe));

   always @(posedge clk_i) begin
      oe_q <= oe;
      if (rd === 1'b1) n_rd <= n_rd + 1;
      if (vwr === 1'b1) n_vwr <= n_vwr + 1;
      if (commit === 1'b1) n_com <= n_com + 1;
      if (gate === 1'b1) n_gate <= n_gate + 1;
      if (oe === 1'b1 && oe_q !== 1'b1) n_oe <= n_oe + 1;
   end
   task automatic chk(input string nm, input logic [63:0] s, e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic t_unlock();
      u_ctrl.send({CMD_WRITE, UNLOCK_ADDR, CODE}, 38, 1'b0);
      chk("unlocked", unl, 1);
      chk("unl_vwr", n_vwr, 0);
      chk("unl_ack", n_oe, 0);
   endtask
   task automatic t_vwrite();
      u_ctrl.send({CMD_WRITE, 6'h21, WD}, 38, 1'b0);
      chk("vwr", n_vwr, 1);
      chk("vwr_req", req, {6'h21, WD});
      chk("vwr_ack", n_oe, 0);
   endtask
   task automatic t_read();
      logic [34:0] r;
      bit          ok;
      u_ctrl.send({30'h0, CMD_READ, 6'h21}, 8, 1'b0);
      chk("rd", n_rd, 1);
      chk("rd_addr", req.addr, 6'h21);
      u_ctrl.recv(r, ok);
      chk("resp_ok", ok, 1);
      chk("resp", r, {2'b00, rdata, u_ctrl.crc3({8'h0, rdata}, 30)});
      chk("resp_n", n_oe, 1);
      repeat (640) @(negedge clk_i);
   endtask
   // Bad CRC, then the two unused type codes
   task automatic t_refuse();
      logic [7:0] pl [3];
      pl = '{{CMD_READ, 6'h21}, {CMD_SPARE, 6'h21}, {CMD_NONE, 6'h21}};
      for (int i = 0; i < 3; i++) begin
         u_ctrl.send({30'h0, pl[i]}, 8, i == 0);
      end
      chk("ref_rd", n_rd, 1);
      chk("ref_ack", n_oe, 1);
   endtask
   task automatic t_nvwrite();
      u_ctrl.send({CMD_WRITE, 6'h05, ~WD}, 38, 1'b0);
      chk("nv_vwr", n_vwr, 1);
      u_ctrl.strobe(STB / 2);
      u_ctrl.strobe(STB + 10);
      chk("nv_early", n_com + n_gate, 0);
      u_ctrl.strobe(STB + 10);
      chk("nv_com", n_com, 1);
      chk("nv_gate", n_gate >= 7 && n_gate <= 12, 1);
      chk("nv_req", req, {6'h05, ~WD});
      chk("nv_life", n_com <= 100, 1);
   endtask
   task automatic t_lockout();
      rst_n_i = 1'b0;
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk("relock", unl, 0);
      u_ctrl.send({30'h0, CMD_READ, 6'h21}, 8, 1'b0);
      chk("early_lko", lko, 0);
      repeat (UNL - 4000) @(negedge clk_i);
      chk("lko", lko, 1);
      u_ctrl.send({30'h0, CMD_READ, 6'h21}, 8, 1'b0);
      chk("lk_rd", n_rd, 1);
      chk("lk_ack", n_oe, 1);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      rst_n_i = 1'b0;
      rdata = 30'h2B6D1F37;
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_unlock();
      t_vwrite();
      t_read();
      t_refuse();
      t_nvwrite();
      t_lockout();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
